// ==== src/caf_pkg.sv ====
/*
 caf_pkg: constants, selector codes and segment states shared by the
 acceptance filter and the bit timer.
 Assumes a single 100 MHz system clock that is already the effective
 (multiplied) oscillator frequency.
*/
package caf_pkg;
	localparam int          ID_W       = 29;
	localparam int          NUM_FILT   = 16;
	localparam int          LEG_FILT   = 6;
	localparam logic [1:0]  MODE_LEGACY = 2'h0;
	localparam logic [4:0]  SEL_MASK0  = 5'h10;
	localparam logic [4:0]  SEL_MASK1  = 5'h11;
	localparam logic [1:0]  MSEL_M0    = 2'h0;
	localparam logic [1:0]  MSEL_M1    = 2'h1;
	localparam logic [1:0]  MSEL_LAST  = 2'h2;
	localparam logic [28:0] FILT_RST   = 29'h0000_0000;
	localparam logic [1:0]  ROLL_MARK  = 2'h3;
	localparam logic [3:0]  BUF_FIRST  = 4'h0;
	localparam logic [3:0]  BUF_SECOND = 4'h1;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          MIN_BIT_NS    = 1000;
	localparam int          MIN_BIT_CYC   = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0]  MIN_TQ     = 5'h08;
	localparam logic [4:0]  MAX_TQ     = 5'h19;
	localparam logic [4:0]  FIXED_TQ   = 5'h04;
	typedef enum logic [3:0] {
		CAF_SEG_SYNC = 4'h1,
		CAF_SEG_PROP = 4'h2,
		CAF_SEG_PH1  = 4'h4,
		CAF_SEG_PH2  = 4'h8
	} caf_seg_t;
endpackage : caf_pkg

// ==== src/caf_bit_timer.sv ====
/*
 caf_bit_timer: quantum prescaler and bit segment sequencer.
 Assumes rx_i is already synchronous to ref_clk_i (1 = recessive).
*/
`timescale 1ns/1ps
`default_nettype none
module caf_bit_timer (
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [5:0] prescaler_i,
	input  wire logic [2:0] prop_len_i,
	input  wire logic [2:0] ph1_len_i,
	input  wire logic [2:0] ph2_len_i,
	input  wire logic       rx_i,
	output logic            tq_tick_o,
	output logic            bit_start_o,
	output logic            sample_o,
	output logic [3:0]      seg_o,
	output logic            rate_ok_o
);
	import caf_pkg::*;
	logic [6:0] pre_cnt_r;
	logic [2:0] tq_cnt_r;
	caf_seg_t   seg_r;
	caf_seg_t   seg_nxt;
	logic       rx_prev_r;
	logic       tick_r;
	logic       start_r;
	logic       samp_r;
	logic       ok_r;
	wire [6:0]  tq_term = {prescaler_i, 1'b1};
	wire        tick    = pre_cnt_r == tq_term;
	wire        fall    = rx_prev_r & ~rx_i;
	// edges inside sync are where they belong; elsewhere restart the bit
	wire        resync  = fall & (seg_r != CAF_SEG_SYNC);
	wire [2:0]  seg_len = (seg_r == CAF_SEG_PROP) ? prop_len_i :
	                      (seg_r == CAF_SEG_PH1)  ? ph1_len_i  :
	                      (seg_r == CAF_SEG_PH2)  ? ph2_len_i  : 3'h0;
	wire        seg_end = tick & (tq_cnt_r == seg_len);
	wire [4:0]  tq_tot  = FIXED_TQ + {2'b00, prop_len_i} + {2'b00, ph1_len_i}
	                      + {2'b00, ph2_len_i};
	wire [7:0]  tq_cyc  = {1'b0, prescaler_i, 1'b0} + 8'h02;
	wire [12:0] bit_cyc = 13'(tq_cyc) * 13'(tq_tot);
	always_comb begin
		case (seg_r)
			CAF_SEG_SYNC: seg_nxt = CAF_SEG_PROP;
			CAF_SEG_PROP: seg_nxt = CAF_SEG_PH1;
			CAF_SEG_PH1:  seg_nxt = CAF_SEG_PH2;
			default:      seg_nxt = CAF_SEG_SYNC;
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_cnt_r <= 7'h00;
			tq_cnt_r  <= 3'h0;
			seg_r     <= CAF_SEG_SYNC;
			rx_prev_r <= 1'b1;
			tick_r    <= 1'b0;
			start_r   <= 1'b0;
			samp_r    <= 1'b0;
			ok_r      <= 1'b0;
		end else begin
			rx_prev_r <= rx_i;
			tick_r    <= tick & ~resync;
			start_r   <= resync | (seg_end & (seg_r == CAF_SEG_PH2));
			samp_r    <= seg_end & (seg_r == CAF_SEG_PH1) & ~resync;
			// bit time 8..25 quanta and no faster than 1 Mb/s
			ok_r      <= (tq_tot >= MIN_TQ) & (tq_tot <= MAX_TQ)
			             & (bit_cyc >= 13'(MIN_BIT_CYC));
			if (resync) begin
				pre_cnt_r <= 7'h00;
				tq_cnt_r  <= 3'h0;
				seg_r     <= CAF_SEG_SYNC;
			end else if (tick) begin
				pre_cnt_r <= 7'h00;
				tq_cnt_r  <= seg_end ? 3'h0 : tq_cnt_r + 3'h1;
				if (seg_end)
					seg_r <= seg_nxt;
			end else begin
				pre_cnt_r <= pre_cnt_r + 7'h01;
			end
		end
	end
	assign tq_tick_o   = tick_r;
	assign bit_start_o = start_r;
	assign sample_o    = samp_r;
	assign seg_o       = seg_r;
	assign rate_ok_o   = ok_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// measured between the registered pulses, independent of the prescaler count
	logic [6:0] gap_r;
	logic [5:0] psc_seen_r;
	logic       gap_v_r;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_r      <= 7'h00;
			psc_seen_r <= 6'h00;
			gap_v_r    <= 1'b0;
		end else begin
			gap_r      <= (tick_r | start_r) ? 7'h00 : gap_r + 7'h01;
			psc_seen_r <= prescaler_i;
			// a prescaler change spoils the quantum in flight
			if (prescaler_i != psc_seen_r)
				gap_v_r <= 1'b0;
			else if (tick_r | start_r)
				gap_v_r <= 1'b1;
		end
	end
	property p_tq_period;
		tick_r && gap_v_r |-> gap_r == {psc_seen_r, 1'b1};
	endproperty
	a_tq_period: assert property (p_tq_period) else $error("quantum length wrong");
	property p_sync_one;
		seg_r == CAF_SEG_SYNC && tick && !resync |=> seg_r == CAF_SEG_PROP;
	endproperty
	a_sync_one: assert property (p_sync_one) else $error("sync not one quantum");
endmodule : caf_bit_timer
`default_nettype wire

// ==== src/caf_accept_filter.sv ====
/*
 caf_accept_filter: identifier acceptance filtering with buffer steering
 and hit coding, plus the bit timer.
 Assumes frame_valid_i pulses once per complete frame held in the
 frame assembly buffer, and that the receive buffers sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
module caf_accept_filter (
	input  wire logic                          ref_clk_i,
	input  wire logic                          rstn_i,
	input  wire logic [1:0]                    mode_i,
	input  wire logic                          config_mode_i,
	input  wire logic                          cfg_wr_i,
	input  wire logic [4:0]                    cfg_sel_i,
	input  wire logic [caf_pkg::ID_W-1:0]      cfg_data_i,
	output logic [caf_pkg::ID_W-1:0]           cfg_rd_data_o,
	output logic                               wr_ignored_o,
	input  wire logic [caf_pkg::NUM_FILT-1:0]  filter_enable_reg_i,
	input  wire logic [4*caf_pkg::NUM_FILT-1:0] filter_buffer_link_reg_i,
	input  wire logic [2*caf_pkg::NUM_FILT-1:0] mask_select_reg_i,
	input  wire logic                          last_is_mask_i,
	input  wire logic                          rollover_enable_i,
	input  wire logic                          first_buf_full_i,
	input  wire logic                          frame_valid_i,
	input  wire logic [caf_pkg::ID_W-1:0]      frame_id_i,
	output logic                               store_o,
	output logic                               drop_o,
	output logic [3:0]                         store_buf_o,
	output logic [4:0]                         filter_hit_code_o,
	output logic [2:0]                         first_ctl_hit_o,
	input  wire logic [5:0]                    quantum_prescaler_i,
	input  wire logic [2:0]                    propagation_length_field_i,
	input  wire logic [2:0]                    phase_buffer_first_i,
	input  wire logic [2:0]                    phase_buffer_second_i,
	input  wire logic                          rx_i,
	output logic                               tq_tick_o,
	output logic                               bit_start_o,
	output logic                               sample_o,
	output logic [3:0]                         seg_o,
	output logic                               rate_ok_o
);
	import caf_pkg::*;

	function automatic logic caf_id_match(input logic [ID_W-1:0] id,
	                                      input logic [ID_W-1:0] filt,
	                                      input logic [ID_W-1:0] mask);
		caf_id_match = &(~mask | ~(id ^ filt));
	endfunction : caf_id_match

	function automatic logic [4:0] caf_lowest(input logic [NUM_FILT-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NUM_FILT - 1; i >= 0; i--) begin
			if (v[i])
				r = 5'(i);
		end
		caf_lowest = r;
	endfunction : caf_lowest

	logic [ID_W-1:0] filt_r [NUM_FILT];
	logic [ID_W-1:0] mask_r [2];
	logic [ID_W-1:0] rd_r;
	logic            ign_r;
	logic            store_r;
	logic            drop_r;
	logic [3:0]      buf_r;
	logic [4:0]      hit_r;
	logic [2:0]      roll_r;

	// programming port; out of configuration mode writes are ignored and flagged, reads still work
	wire cfg_ok = cfg_wr_i & config_mode_i;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_FILT; i++)
				filt_r[i] <= FILT_RST;
			mask_r[0] <= FILT_RST;
			mask_r[1] <= FILT_RST;
		end else if (cfg_ok) begin
			if (!cfg_sel_i[4])
				filt_r[cfg_sel_i[3:0]] <= cfg_data_i;
			else if (cfg_sel_i == SEL_MASK0)
				mask_r[0] <= cfg_data_i;
			else if (cfg_sel_i == SEL_MASK1)
				mask_r[1] <= cfg_data_i;
		end
	end

	wire [ID_W-1:0] rd_val = !cfg_sel_i[4]            ? filt_r[cfg_sel_i[3:0]] :
	                         (cfg_sel_i == SEL_MASK0) ? mask_r[0] :
	                         (cfg_sel_i == SEL_MASK1) ? mask_r[1] : '0;

	wire legacy = mode_i == MODE_LEGACY;
	logic [ID_W-1:0]     fmask [NUM_FILT];
	logic [NUM_FILT-1:0] enh_hit;
	logic [NUM_FILT-1:0] leg_hit;
	for (genvar n = 0; n < NUM_FILT; n++) begin : g_filt
		wire [1:0] msel = mask_select_reg_i[2*n +: 2];
		// code 3 links no mask: that filter accepts every identifier
		assign fmask[n] = (msel == MSEL_M0) ? mask_r[0] :
		                  (msel == MSEL_M1) ? mask_r[1] :
		                  (msel == MSEL_LAST && last_is_mask_i) ? filt_r[NUM_FILT-1] :
		                  '0;
		wire as_mask = (n == NUM_FILT - 1) && last_is_mask_i;
		assign enh_hit[n] = filter_enable_reg_i[n] & ~as_mask
		                    & caf_id_match(frame_id_i, filt_r[n], fmask[n]);
		if (n < LEG_FILT) begin : g_leg
			wire [ID_W-1:0] lmask = (n < 2) ? mask_r[0] : mask_r[1];
			assign leg_hit[n] = caf_id_match(frame_id_i, filt_r[n], lmask);
		end else begin : g_noleg
			assign leg_hit[n] = 1'b0;
		end
	end

	// legacy steering: low pair to the first buffer, or to the second on rollover; the rest to the second
	wire [4:0] leg_idx   = caf_lowest(leg_hit);
	wire       leg_any   = |leg_hit;
	wire       leg_first = leg_any & (leg_idx < 5'h02);
	wire       leg_roll  = leg_first & first_buf_full_i & rollover_enable_i;
	// full first buffer without rollover is an overflow: frame lost
	wire       leg_store = leg_any & ~(leg_first & first_buf_full_i & ~rollover_enable_i);
	wire [3:0] leg_buf   = (leg_first & ~leg_roll) ? BUF_FIRST : BUF_SECOND;
	wire [2:0] leg_roll_code = leg_roll ? {ROLL_MARK, leg_idx[0]} : leg_idx[2:0];

	wire [4:0] enh_idx = caf_lowest(enh_hit);
	wire       enh_any = |enh_hit;
	wire [3:0] enh_buf = filter_buffer_link_reg_i[{enh_idx[3:0], 2'b00} +: 4];

	wire       acc_any = legacy ? leg_store : enh_any;
	wire [3:0] acc_buf = legacy ? leg_buf : enh_buf;
	wire [4:0] acc_hit = legacy ? {2'b00, leg_idx[2:0]} : enh_idx;
	wire [2:0] acc_cod = legacy ? leg_roll_code : enh_idx[2:0];

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			store_r <= 1'b0;
			drop_r  <= 1'b0;
			buf_r   <= BUF_FIRST;
			hit_r   <= 5'h00;
			roll_r  <= 3'h0;
			rd_r    <= FILT_RST;
			ign_r   <= 1'b0;
		end else begin
			store_r <= frame_valid_i & acc_any;
			drop_r  <= frame_valid_i & ~acc_any;
			rd_r    <= rd_val;
			ign_r   <= cfg_wr_i & ~config_mode_i;
			if (frame_valid_i & acc_any) begin
				buf_r  <= acc_buf;
				hit_r  <= acc_hit;
				roll_r <= acc_cod;
			end
		end
	end
	assign store_o           = store_r;
	assign drop_o            = drop_r;
	assign store_buf_o       = buf_r;
	assign filter_hit_code_o = hit_r;
	assign first_ctl_hit_o   = roll_r;
	assign cfg_rd_data_o     = rd_r;
	assign wr_ignored_o      = ign_r;

	caf_bit_timer u_timer (
		.ref_clk_i   (ref_clk_i),
		.rstn_i      (rstn_i),
		.prescaler_i (quantum_prescaler_i),
		.prop_len_i  (propagation_length_field_i),
		.ph1_len_i   (phase_buffer_first_i),
		.ph2_len_i   (phase_buffer_second_i),
		.rx_i        (rx_i),
		.tq_tick_o   (tq_tick_o),
		.bit_start_o (bit_start_o),
		.sample_o    (sample_o),
		.seg_o       (seg_o),
		.rate_ok_o   (rate_ok_o)
	);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_leg_frame;
		frame_valid_i && legacy;
	endsequence
	sequence s_roll_req;
		s_leg_frame ##0 (leg_hit[1] && !leg_hit[0] && first_buf_full_i && rollover_enable_i);
	endsequence
	sequence s_enh_frame;
		frame_valid_i && !legacy;
	endsequence

	property p_mask_zero;
		s_leg_frame ##0 (mask_r[0] == '0 && !first_buf_full_i)
		|=> store_o && store_buf_o == BUF_FIRST && filter_hit_code_o == 5'h00;
	endproperty
	a_mask_zero: assert property (p_mask_zero) else $error("zero mask not accepted");

	property p_mask_one;
		s_leg_frame ##0 (mask_r[0] == '1 && mask_r[1] == '1
		&& frame_id_i != filt_r[0] && frame_id_i != filt_r[1]
		&& frame_id_i != filt_r[2] && frame_id_i != filt_r[3]
		&& frame_id_i != filt_r[4] && frame_id_i != filt_r[5]) |=> drop_o && !store_o;
	endproperty
	a_mask_one: assert property (p_mask_one) else $error("full mask mismatch accepted");

	property p_one_answer;
		frame_valid_i |=> (store_o ^ drop_o);
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("frame got no single answer");

	property p_no_frame;
		!frame_valid_i |=> !store_o && !drop_o;
	endproperty
	a_no_frame: assert property (p_no_frame) else $error("answer without frame");

	property p_leg_second;
		s_leg_frame ##0 (leg_hit[3] && leg_hit[5] && leg_hit[2:0] == 3'h0)
		|=> store_o && store_buf_o == BUF_SECOND && filter_hit_code_o == 5'h03;
	endproperty
	a_leg_second: assert property (p_leg_second) else $error("legacy second buffer hit wrong");

	property p_roll;
		s_roll_req |=> store_buf_o == BUF_SECOND && filter_hit_code_o == 5'h01
		&& first_ctl_hit_o == 3'h7;
	endproperty
	a_roll: assert property (p_roll) else $error("rollover not applied");

	property p_no_roll;
		s_leg_frame ##0 (leg_hit[0] && first_buf_full_i && !rollover_enable_i) |=> drop_o;
	endproperty
	a_no_roll: assert property (p_no_roll) else $error("overflow frame stored");

	property p_enh_disabled;
		frame_valid_i && !legacy && filter_enable_reg_i == '0 |=> drop_o;
	endproperty
	a_enh_disabled: assert property (p_enh_disabled) else $error("disabled filters accepted");

	property p_enh_prio;
		frame_valid_i && !legacy && enh_hit[4] && enh_hit[9] && enh_hit[3:0] == 4'h0
		|=> store_o && filter_hit_code_o == 5'h04
		&& store_buf_o == $past(filter_buffer_link_reg_i[19:16]);
	endproperty
	a_enh_prio: assert property (p_enh_prio) else $error("lowest filter not chosen");

	property p_last_mask;
		frame_valid_i && !legacy && last_is_mask_i && enh_hit[14:0] == '0 |=> drop_o;
	endproperty
	a_last_mask: assert property (p_last_mask) else $error("last filter matched as mask");

	property p_cfg_lock;
		cfg_wr_i && !config_mode_i |=> $stable(filt_r[0]) && $stable(mask_r[0])
		&& $stable(mask_r[1]) && wr_ignored_o;
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("write outside configuration");

	property p_rate;
		##1 $stable(quantum_prescaler_i) && quantum_prescaler_i == 6'h00
		&& $stable(propagation_length_field_i) |=> !rate_ok_o;
	endproperty
	a_rate: assert property (p_rate) else $error("bit faster than 1 Mb/s allowed");

	property p_leg_pair;
		s_leg_frame ##0 (leg_hit[1] && !leg_hit[0] && !first_buf_full_i)
		|=> store_o && store_buf_o == BUF_FIRST && filter_hit_code_o == 5'h01
		&& first_ctl_hit_o == 3'h1;
	endproperty
	a_leg_pair: assert property (p_leg_pair) else $error("first pair not in first buffer");

	property p_enh_link;
		s_enh_frame ##0 enh_hit[0]
		|=> store_o && filter_hit_code_o == 5'h00
		&& store_buf_o == $past(filter_buffer_link_reg_i[3:0]);
	endproperty
	a_enh_link: assert property (p_enh_link) else $error("filter zero steered wrong");

	property p_enh_top;
		s_enh_frame ##0 (enh_hit == 16'h8000) |=> store_o && filter_hit_code_o == 5'h0F;
	endproperty
	a_enh_top: assert property (p_enh_top) else $error("hit field not fifteen");

	property p_low_code;
		store_o && $past(legacy) && store_buf_o == BUF_SECOND && filter_hit_code_o < 5'h02
		|-> $past(rollover_enable_i) && first_ctl_hit_o[2:1] == ROLL_MARK;
	endproperty
	a_low_code: assert property (p_low_code) else $error("low hit code without rollover");
endmodule : caf_accept_filter
`default_nettype wire

// ==== tb/caf_bus_node.sv ====
/*
 caf_bus_node: another node on the shared bus, sending stuffed NRZ words.
 Assumes the bench clock and a bench-supplied data word; idles recessive.
*/
`timescale 1ns/1ps
`default_nettype none
module caf_bus_node #(
	parameter int BIT_CYC = 37
) (
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [31:0] data_i,
	output logic             rx_o
);
	int          run;
	logic        last;
	logic [31:0] word;

	// same nominal rate, slightly slower oscillator, so edges drift off sync
	task automatic send(input logic b);
		rx_o <= b;
		run = (b == last) ? run + 1 : 1;
		last = b;
		repeat (BIT_CYC) @(posedge clk_i);
	endtask : send

	initial begin
		rx_o = 1'b1;
		run = 0;
		last = 1'b1;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				word = data_i;
				for (int i = 31; i >= 0; i--) begin
					send(word[i]);
					if (run == 5) send(!last);
				end
			end else begin
				rx_o <= 1'b1;
			end
		end
	end
endmodule : caf_bus_node
`default_nettype wire

// ==== tb/test_can_accept_filter_bit_timing.sv ====
/*
 test_can_accept_filter_bit_timing: self-checking bench with a reference
 filter model and bit-timing measurements. Assumes caf_pkg and the
 design files are compiled first, and caf_bus_node for the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module test_can_accept_filter_bit_timing;
	import caf_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0, cfg_mode = 1'b0, cfg_wr = 1'b0, fv = 1'b0, go = 1'b0;
	logic        last_mask = 1'b0, roll = 1'b0, full = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic [4:0]  sel = 5'h00;
	logic [28:0] cdat = 29'h0, fid = 29'h0;
	logic [15:0] fen = 16'h0;
	logic [63:0] link = 64'h0;
	logic [31:0] msel = 32'h0, pdata = 32'h0, rs = 32'h0001_330E;
	logic [5:0]  psc = 6'h00;
	logic [2:0]  prl = 3'h0, p1 = 3'h0, p2 = 3'h0;
	wire logic   rx;
	logic        wig, st, dr, tick, bs, smp, rok;
	logic [28:0] rdat;
	logic [3:0]  sb, seg, lb = 4'h0;
	logic [4:0]  hit, lh = 5'h00;
	logic [2:0]  fc, lc = 3'h0;
	logic [28:0] mf [16] = '{default: 29'h0};
	logic [28:0] mm [2] = '{default: 29'h0};
	int          n_mismatch = 0, checks = 0, pend = 0;
	logic        prx = 1'b1;

	caf_accept_filter caf_accept_filter_i (
		.ref_clk_i(clk), .rstn_i(rstn), .mode_i(mode), .config_mode_i(cfg_mode),
		.cfg_wr_i(cfg_wr), .cfg_sel_i(sel), .cfg_data_i(cdat), .cfg_rd_data_o(rdat),
		.wr_ignored_o(wig), .filter_enable_reg_i(fen), .filter_buffer_link_reg_i(link),
		.mask_select_reg_i(msel), .last_is_mask_i(last_mask), .rollover_enable_i(roll),
		.first_buf_full_i(full), .frame_valid_i(fv), .frame_id_i(fid), .store_o(st),
		.drop_o(dr), .store_buf_o(sb), .filter_hit_code_o(hit), .first_ctl_hit_o(fc),
		.quantum_prescaler_i(psc), .propagation_length_field_i(prl),
		.phase_buffer_first_i(p1), .phase_buffer_second_i(p2), .rx_i(rx),
		.tq_tick_o(tick), .bit_start_o(bs), .sample_o(smp), .seg_o(seg), .rate_ok_o(rok)
	);
	caf_bus_node #(.BIT_CYC(37)) caf_bus_node_i (
		.clk_i(clk), .go_i(go), .data_i(pdata), .rx_o(rx)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd

	task automatic wrap_up();
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %0h want %0h", $time, m, g, e);
		end
	endtask : chk_val

	task automatic chk_frame(input logic s);
		checks++;
		if ({st, dr, sb, hit, fc} !== {s, !s, lb, lh, lc}) begin
			n_mismatch++;
			$display("CHECK FAILED %0t frame id %h", $time, fid);
		end
	endtask : chk_frame

	// lowest number wins because the scan runs downward and overwrites
	task automatic model(input logic [28:0] id, output logic s, output logic [3:0] b,
	                     output logic [4:0] h, output logic [2:0] c);
		int w;
		logic [28:0] m;
		w = -1;
		if (mode == 2'h0) begin
			for (int n = 5; n >= 0; n--) if (((id ^ mf[n]) & mm[n > 1]) == 29'h0) w = n;
			if (w >= 0 && w < 2 && full) begin
				b = 4'h1;
				c = {2'h3, 1'(w)};
				if (!roll) w = -1;
			end else begin
				b = (w > 1) ? 4'h1 : 4'h0;
				c = 3'(w);
			end
		end else begin
			for (int n = 15; n >= 0; n--) begin
				case (msel[2*n +: 2])
					2'h0: m = mm[0];
					2'h1: m = mm[1];
					2'h2: m = mf[15];
					default: m = 29'h0;
				endcase
				if (fen[n] && !(n == 15 && last_mask) && ((id ^ mf[n]) & m) == 29'h0) w = n;
			end
			if (w >= 0) b = link[4*w +: 4];
			c = 3'(w);
		end
		s = (w >= 0);
		h = 5'(w);
	endtask : model

	task automatic wr(input logic [4:0] s, input logic [28:0] d, input logic cm);
		@(posedge clk);
		cfg_wr <= 1'b1; sel <= s; cdat <= d; cfg_mode <= cm;
		@(posedge clk);
		cfg_wr <= 1'b0; cfg_mode <= 1'b0;
		if (cm && s < 16) mf[s[3:0]] = d;
		else if (cm && s < 18) mm[s[0]] = d;
		#1 chk_val(32'(wig), 32'(!cm), "ignored write flag");
	endtask : wr

	task automatic rd(input logic [4:0] s);
		@(posedge clk);
		sel <= s;
		repeat (2) @(posedge clk);
		#1 chk_val(32'(rdat), (s < 16) ? 32'(mf[s[3:0]]) : (s < 18) ? 32'(mm[s[0]]) : 32'h0,
		           "readback");
	endtask : rd

	task automatic fr(input logic [28:0] id, input logic fl);
		logic s;
		logic [3:0] b;
		logic [4:0] h;
		logic [2:0] c;
		@(posedge clk);
		fv <= 1'b1; fid <= id; full <= fl;
		@(posedge clk);
		fv <= 1'b0;
		model(id, s, b, h, c);
		#1;
		if (s) {lb, lh, lc} = {b, h, c};
		chk_frame(s);
	endtask : fr

	task automatic gap(input bit b, output int d);
		int k;
		k = 0;
		d = 0;
		while ((b ? bs : tick) !== 1'b1 && k < 2000) begin @(posedge clk); #1; k++; end
		do begin @(posedge clk); #1; d++; end while ((b ? bs : tick) !== 1'b1 && d < 2000);
	endtask : gap

	task automatic timer(input logic [5:0] p, input logic [2:0] a, b, c);
		int d, q, nb, s;
		@(posedge clk);
		psc <= p; prl <= a; p1 <= b; p2 <= c;
		repeat (2) gap(1, d);
		q = 2 * (p + 1);
		nb = 4 + a + b + c;
		gap(0, d);
		chk_val(d, q, "quantum length");
		gap(1, d);
		chk_val(d, q * nb, "bit length");
		s = 0;
		while (seg === CAF_SEG_SYNC && s < 999) begin @(posedge clk); #1; s++; end
		chk_val(s, q, "sync length");
		while (smp !== 1'b1 && s < 2000) begin @(posedge clk); #1; s++; end
		chk_val(s, q * (3 + a + b), "sample point");
		chk_val(32'(rok), 32'(nb >= 8 && nb <= 25 && q * nb >= 100), "rate flag");
	endtask : timer

	// a falling edge outside sync must restart the bit within a few clocks
	always @(posedge clk) begin
		if (pend != 0 && (bs === 1'b1 || pend == 3)) begin
			chk_val(32'(bs), 32'h1, "resync");
			pend = 0;
		end else if (pend != 0) begin
			pend++;
		end
		if (prx === 1'b1 && rx === 1'b0 && seg !== CAF_SEG_SYNC && rstn) pend = 1;
		prx = rx;
	end

	initial begin
		#500_000;
		n_mismatch++;
		wrap_up();
	end

	initial begin
		logic [31:0] v, mt;
		logic [28:0] id;
		repeat (11) @(posedge clk);
		#1 chk_val(32'({seg, st, dr, rok, wig}), 32'h0000_0010, "reset values");
		@(posedge clk);
		rstn <= 1'b1;
		for (int r = 0; r < 10; r++) begin
			// pass 4 opens mask zero, pass 8 closes both masks fully
			for (int s = 0; s < 18; s++) begin
				v = (s < 16) ? rnd() : (r == 8) ? 32'h1FFF_FFFF : rnd() & rnd();
				if (r == 4 && s == 16) v = 32'h0000_0000;
				wr(5'(s), 29'(v), 1'b1);
			end
			wr(5'(20 + r), 29'(rnd()), 1'b1);
			rd(5'(20 + r));
			v = rnd();
			wr(5'(v[3:0]), 29'(rnd()), 1'b0);
			rd(5'(v[3:0]));
			rd(5'(16 + v[4]));
			mt = rnd();
			for (int j = 0; j < 16; j++) if (mt[2*j +: 2] == 2'h2 && !v[5]) mt[2*j +: 2] = 2'h3;
			@(posedge clk);
			mode <= 2'(r); last_mask <= v[5]; roll <= v[6]; fen <= v[31:16]; msel <= mt;
			link <= {rnd(), rnd()};
			for (int f = 0; f < 40; f++) begin
				v = rnd();
				id = (v[6:4] == 3'h0) ? 29'(rnd()) : mf[v[3:0]] ^ 29'(rnd() & rnd() & rnd());
				fr(id, v[7] & (r % 4 == 0));
			end
		end
		timer(6'h00, 3'h1, 3'h1, 3'h2);
		timer(6'h03, 3'h7, 3'h7, 3'h7);
		timer(6'h3F, 3'h0, 3'h0, 3'h0);
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			timer(v[5:0] & 6'h07, v[8:6], v[11:9], v[14:12]);
		end
		timer(6'h01, 3'h1, 3'h2, 3'h2);
		go <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			pdata <= rnd();
			repeat (1200) @(posedge clk);
		end
		go <= 1'b0;
		repeat (400) @(posedge clk);
		wrap_up();
	end
endmodule : test_can_accept_filter_bit_timing
`default_nettype wire
